// file: include/gprs_pkg.sv
// Purpose: constants, types and helpers of the gyro power-up/reset sequencer
// Assumes: 125 MHz i_mclk, 16-bit serial words, host is the serial master
// Notes:   rate data and monitor flags arrive from on-chip logic
//
// How it works
// R1: rate data valid right after start-up, no commands
// R2: host enables digital supply, waits 10 ms
// R3: host waits 800 ms, reads status twice
// R4: start-up flags held until two status reads
// R5: writing 0x04 to ident register resets core
// R6: low external reset pin holds core in reset
// R7: host releases reset pin after supplies settle
// R8: register-write reset applied after full data word
// R9: 16-bit words, first word carries address
// R10: read result returned during the following word
package gprs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLK_KHZ     = 125_000;
    localparam int unsigned STARTUP_MS  = 800;
    localparam int unsigned STARTUP_CYC = STARTUP_MS * CLK_KHZ;
    localparam int          START_W     = 27;

    ////////////////////////////////////////////////////////////////////////
    // word layout
    localparam int          WORD_W    = 16;
    localparam logic [3:0]  BIT_LAST  = 4'hF;
    localparam int          ADR_LSB   = 3;
    localparam int          ADR_MSB   = 9;
    localparam int          RW_BIT    = 2;
    localparam int          S_OK_BIT  = 1;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [6:0]  ADDR_RATE   = 7'h00;
    localparam logic [6:0]  ADDR_IDENT  = 7'h07;
    localparam logic [6:0]  ADDR_STATUS = 7'h08;
    localparam logic [14:0] RESET_CODE  = 15'h0004;
    // identification value is arbitrary
    localparam logic [14:0] IDENT_VALUE = 15'h0123;
    localparam int          MON_W       = 4;
    localparam int          ST_START    = 4;
    localparam logic [4:0]  STATUS_RST  = 5'h00;
    localparam logic [14:0] RATE_RST    = 15'h0000;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        PH_ADDR = 2'b01,
        PH_DATA = 2'b10
    } gprs_phase_t;

    typedef struct packed {
        logic sclk;
        logic mosi;
        logic serial_select_n;
    } gprs_spi_in_t;

    typedef struct packed {
        logic miso;
        logic miso_oe;
    } gprs_spi_out_t;

    typedef struct packed {
        logic [1:0]         sclk_s;
        logic [1:0]         mosi_s;
        logic [1:0]         sel_s;
        logic [1:0]         extn_s;
        logic               sclk_d;
        logic [3:0]         bit_cnt;
        logic [14:0]        rx;
        logic [15:0]        tx;
        logic               miso;
        gprs_phase_t        phase;
        logic [6:0]         wr_addr;
        logic               stat_read1;
        logic [4:0]         status;
        logic [14:0]        rate;
        logic [START_W-1:0] start_cnt;
        logic               started;
        logic               core_rst;
    } gprs_state_t;

    // 15-bit value plus odd parity in bit 0
    function automatic logic [15:0] gprs_word(input logic [14:0] v);
        return {v, ~^v};
    endfunction : gprs_word

endpackage : gprs_pkg

// file: core/gprs_core.sv
// Purpose: serial slave, start-up timer, status flags and reset handling
// Assumes: host pins are asynchronous and are synchronised here
// Notes:   serial clock must stay well below i_mclk / 8
`timescale 1ns/1ps
module gprs_core
    import gprs_pkg::*;
#(
    parameter int unsigned STARTUP_CYCLES = STARTUP_CYC
) (
    // clock and reset
    input  wire logic               i_mclk,
    input  wire logic               i_rst,
    // host pins
    input  wire gprs_spi_in_t       i_spi,
    input  wire logic               i_external_reset_n,
    output gprs_spi_out_t           o_spi,
    // sensing core
    input  wire logic [14:0]        i_rate,
    input  wire logic               i_rate_valid,
    input  wire logic [MON_W-1:0]   i_mon_err,
    output logic                    o_ready,
    output logic                    o_core_reset
);

    localparam logic [START_W-1:0] START_LAST =
        START_W'(STARTUP_CYCLES - 1);

    // power-on value of all state: select idles high, core held in reset
    localparam gprs_state_t Q_RST = '{
        sclk_s: 2'h0, mosi_s: 2'h0, sel_s: 2'h3, extn_s: 2'h0,
        sclk_d: 1'b0, bit_cnt: 4'h0, rx: 15'h0000, tx: 16'h0000,
        miso: 1'b0, phase: PH_ADDR, wr_addr: 7'h00,
        stat_read1: 1'b0, status: STATUS_RST, rate: RATE_RST,
        start_cnt: '0, started: 1'b0, core_rst: 1'b1};

    gprs_state_t q;
    gprs_state_t next_q;

    ////////////////////////////////////////////////////////////////////////
    // decode of synchronised pins
    logic        sel_act;
    logic        rise;
    logic        fall;
    logic        word_done;
    logic [15:0] word;
    logic [6:0]  word_addr;
    logic        rd_req;
    logic        data_done;
    logic        soft_hit;
    logic        stat_clr;
    logic [4:0]  stat_set;
    logic [15:0] flags_word;

    assign sel_act   = ~q.sel_s[1];
    assign rise      = sel_act & q.sclk_s[1] & ~q.sclk_d;
    assign fall      = sel_act & ~q.sclk_s[1] & q.sclk_d;
    assign word      = {q.rx, q.mosi_s[1]};
    assign word_addr = word[ADR_MSB:ADR_LSB];
    assign word_done = rise & (q.bit_cnt == BIT_LAST);     // see R9
    assign rd_req    = word_done & (q.phase == PH_ADDR) & ~word[RW_BIT];
    assign data_done = word_done & (q.phase == PH_DATA);
    // reset only once the whole data word is in
    assign soft_hit  = data_done & (q.wr_addr == ADDR_IDENT)
                     & (word[15:1] == RESET_CODE);       // see R5 see R8
    assign stat_clr  = rd_req & (word_addr == ADDR_STATUS)
                     & q.stat_read1;                      // see R4
    assign stat_set  = {~q.started, i_mon_err};
    assign flags_word = gprs_word({14'h0000, q.status == STATUS_RST});

    function automatic logic [14:0] reg_value(input logic [6:0] a);
        case (a)
            ADDR_RATE:   reg_value = q.rate;
            ADDR_IDENT:  reg_value = IDENT_VALUE;
            ADDR_STATUS: reg_value = {10'h000, q.status};
            default:     reg_value = 15'h0000;
        endcase
    endfunction : reg_value

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_q = q;
        next_q.sclk_s = {q.sclk_s[0], i_spi.sclk};
        next_q.mosi_s = {q.mosi_s[0], i_spi.mosi};
        next_q.sel_s  = {q.sel_s[0], i_spi.serial_select_n};
        next_q.extn_s = {q.extn_s[0], i_external_reset_n};
        next_q.sclk_d = q.sclk_s[1];
        next_q.core_rst = soft_hit | ~q.extn_s[1];        // see R6

        if (q.core_rst) begin
            next_q.start_cnt  = '0;
            next_q.started    = 1'b0;
            next_q.rate       = RATE_RST;
            next_q.status     = STATUS_RST;
            next_q.stat_read1 = 1'b0;
        end else begin
            if (!q.started) begin
                if (q.start_cnt == START_LAST) begin
                    next_q.started = 1'b1;
                end else begin
                    next_q.start_cnt = q.start_cnt + 1'b1;
                end
            end
            // no command needed: samples flow once start-up is over
            if (q.started && i_rate_valid) begin
                next_q.rate = i_rate;                    // see R1
            end
            // a new flag wins over the clearing read
            if (stat_clr) begin
                next_q.status = STATUS_RST;
            end
            next_q.status = next_q.status | stat_set;    // see R4
        end

        if (!sel_act) begin
            next_q.bit_cnt = 4'h0;
            next_q.phase   = PH_ADDR;
            next_q.tx      = {flags_word[14:0], 1'b0};
            next_q.miso    = flags_word[15];
        end else if (fall) begin
            next_q.miso = q.tx[15];
            next_q.tx   = {q.tx[14:0], 1'b0};
        end else if (rise) begin
            next_q.rx      = {q.rx[13:0], q.mosi_s[1]};
            next_q.bit_cnt = q.bit_cnt + 4'h1;
            if (word_done) begin
                if (data_done) begin
                    next_q.phase = PH_ADDR;
                    next_q.tx    = flags_word;
                end else begin
                    // read and write both answer with the current value
                    next_q.tx = gprs_word(reg_value(word_addr)); // see R10
                    if (word[RW_BIT]) begin
                        next_q.phase   = PH_DATA;
                        next_q.wr_addr = word_addr;
                    end
                    if (!q.core_rst) begin
                        next_q.stat_read1 = rd_req & ~q.stat_read1
                            & (word_addr == ADDR_STATUS);
                    end
                end
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            q <= Q_RST;
        end else begin
            q <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_spi         = '{miso: q.miso, miso_oe: sel_act};
    assign o_ready       = q.started;
    assign o_core_reset  = q.core_rst;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    ext_reset_hold_a: assert property ( // see R6
        !q.extn_s[1] |=> o_core_reset ##1 !o_ready)
        else $error("external reset did not hold core");

    soft_reset_a: assert property ( // see R5
        soft_hit |=> o_core_reset ##1 (!o_ready && q.start_cnt == '0))
        else $error("reset code write did not reset core");

    reset_after_word_a: assert property ( // see R8
        $rose(o_core_reset) && $past(q.extn_s[1]) |-> $past(data_done))
        else $error("register reset not at word end");

    no_rate_early_a: assert property ( // see R1
        !o_ready |-> q.rate == RATE_RST)
        else $error("rate visible before start-up done");

    rate_capture_a: assert property ( // see R1
        o_ready && i_rate_valid && !o_core_reset |=> q.rate == $past(i_rate))
        else $error("rate sample not taken after start-up");

    flag_sticky_a: assert property ( // see R4
        q.status != STATUS_RST && !stat_clr && !q.core_rst
        |=> q.status != STATUS_RST)
        else $error("status flags lost without double read");

    double_read_clr_a: assert property ( // see R4
        stat_clr && stat_set == 5'h00 && !q.core_rst
        |=> q.status == STATUS_RST)
        else $error("double status read did not clear");

    read_result_a: assert property ( // see R10
        word_done && q.phase == PH_ADDR && word_addr == ADDR_IDENT
        |=> q.tx == gprs_word(IDENT_VALUE))
        else $error("read result not loaded for next word");

    miso_shift_a: assert property ( // see R10
        fall |=> q.miso == $past(q.tx[15]))
        else $error("answer bit not shifted on falling clock");

    single_read_keep_a: assert property ( // see R4
        rd_req && word_addr == ADDR_STATUS && !q.stat_read1
        && !q.core_rst && q.status != STATUS_RST |=> q.status != STATUS_RST)
        else $error("one status read cleared the flags");

    ready_after_count_a: assert property ( // see R1
        !q.core_rst && !q.started && q.start_cnt == START_LAST |=> o_ready)
        else $error("start-up end did not raise ready");

    word_parity_a: assert property ( // see R9
        word_done |=> ^q.tx)
        else $error("answer word lacks odd parity");

    bit_count_a: assert property ( // see R9
        sel_act && rise && q.bit_cnt != BIT_LAST |=> q.phase == $past(q.phase))
        else $error("phase changed inside a word");

    soft_reset_c: cover property (soft_hit ##[1:4] o_core_reset);
    status_clear_c: cover property (stat_clr);
    rate_read_c: cover property (rd_req && word_addr == ADDR_RATE && o_ready);
    write_phase_c: cover property (q.phase == PH_DATA ##[1:300] data_done);

endmodule : gprs_core

// file: tb/gprs_host.sv
// Purpose: host model, serial master and reset pin driver
// Assumes: sclk idles low, each half period is 6 i_mclk
// Notes:   the supply ramp is modelled as the pin-low interval
`timescale 1ns/1ps
module gprs_host
    import gprs_pkg::*;
(
    // clock
    input  wire logic          i_mclk,
    // device pins
    input  wire gprs_spi_out_t i_spi,
    output gprs_spi_in_t       o_spi,
    output logic               o_external_reset_n
);
    initial begin
        o_spi = '{sclk: 1'b0, mosi: 1'b0, serial_select_n: 1'b1};
        o_external_reset_n = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : tick
    // raised only once both supplies are up, digital one first
    task automatic pin(input logic v);
        o_external_reset_n = v;
    endtask : pin
    // msb first; miso is taken just before the rising edge
    task automatic xfer(input logic [15:0] tx, input int n,
                        output logic [15:0] rx);
        rx = 16'h0000;
        for (int i = 15; i > 15 - n; i--) begin
            o_spi.mosi = tx[i];
            tick(6);
            rx[i] = i_spi.miso;
            o_spi.sclk = 1'b1;
            tick(6);
            o_spi.sclk = 1'b0;
        end
    endtask : xfer
    // a short last word makes select rise mid-word
    task automatic frame(input logic [15:0] tx[$], input int nlast,
                         output logic [15:0] rx[$]);
        logic [15:0] w;
        rx = {};
        o_spi.serial_select_n = 1'b0;
        tick(6);
        foreach (tx[k]) begin
            xfer(tx[k], (k == tx.size() - 1) ? nlast : 16, w);
            rx.push_back(w);
        end
        tick(6);
        o_spi.serial_select_n = 1'b1;
        // pulled down once released
        o_spi.mosi = 1'b0;
        tick(12);
    endtask : frame
endmodule : gprs_host

// file: tb/gprs_core_tb_top.sv
// Purpose: self-checking bench of the sequencer core
// Assumes: shortened start-up count, host model drives the pins
// Notes:   random rate samples and monitor pulses from a fixed seed
`timescale 1ns/1ps
module gprs_core_tb_top
    import gprs_pkg::*;
;
    localparam int unsigned SU = 100;
    logic          i_mclk, i_rst, i_rate_valid, o_ready, o_core_reset, ext_n;
    logic [14:0]   i_rate;
    logic [3:0]    i_mon_err;
    gprs_spi_in_t  spi_i;
    gprs_spi_out_t spi_o;
    logic [15:0]   rx[$];
    int            fail_count = 0, n_compared = 0, cyc = 0, rst_cnt = 0;

    gprs_core #(.STARTUP_CYCLES(SU)) i_dut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_spi(spi_i),
        .i_external_reset_n(ext_n), .o_spi(spi_o), .i_rate(i_rate),
        .i_rate_valid(i_rate_valid), .i_mon_err(i_mon_err),
        .o_ready(o_ready), .o_core_reset(o_core_reset));
    gprs_host i_host (.i_mclk(i_mclk), .i_spi(spi_o), .o_spi(spi_i),
        .o_external_reset_n(ext_n));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] odd(input logic [14:0] v);
        return {v, ~^v};
    endfunction : odd
    function automatic logic [15:0] aw(input logic [6:0] a, input logic w);
        return odd({6'h00, a, w, 1'b0});
    endfunction : aw
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    task automatic wait_ready(output int n);
        n = 0;
        while (o_ready !== 1'b1 && n < 400) begin
            i_host.tick(1);
            n++;
        end
        chk(16'(o_ready), 16'h0001);
    endtask : wait_ready

    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    // hang guard; also counts cycles of core reset
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (o_core_reset === 1'b1) rst_cnt <= rst_cnt + 1;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        logic [14:0] r;
        logic [14:0] er;
        logic [3:0]  m;
        logic        v;
        int          n;
        void'($urandom(32'h918e0254));
        i_rst = 1'b1;
        i_rate = 15'h0000;
        i_rate_valid = 1'b0;
        i_mon_err = 4'h0;
        repeat (12) @(posedge i_mclk);
        #1;
        i_rst = 1'b0;
        i_host.tick(30);
        chk(16'(o_core_reset), 16'h0001);
        chk(16'(spi_o.miso_oe), 16'h0000);
        i_host.pin(1'b1);
        wait_ready(n);
        chk(16'(n >= SU), 16'h0001);
        i_host.frame('{aw(ADDR_STATUS, 1'b0), aw(ADDR_STATUS, 1'b0),
            16'h0000}, 16, rx);
        chk(rx[1], odd(15'h0010));
        chk(rx[2], odd(15'h0010));
        for (int k = 0; k < 4; k++) begin
            r = 15'($urandom);
            m = 4'h1 << ($urandom % MON_W);
            // first pass always captures, later ones may skip the sample
            v = (k == 0) || 1'($urandom);
            er = v ? r : er;
            i_rate = r;
            i_rate_valid = v;
            i_mon_err = m;
            i_host.tick(1);
            i_rate_valid = 1'b0;
            i_mon_err = 4'h0;
            i_host.frame('{aw(ADDR_STATUS, 1'b0), aw(ADDR_STATUS, 1'b0),
                aw(ADDR_STATUS, 1'b0), aw(ADDR_RATE, 1'b0), 16'h0000}, 16, rx);
            chk(rx[0], 16'h0001);
            chk(rx[1], odd({11'h000, m}));
            chk(rx[2], odd({11'h000, m}));
            chk(rx[3], 16'h0001);
            chk(rx[4], odd(er));
        end
        rst_cnt = 0;
        i_host.frame('{aw(7'h05, 1'b0), aw(ADDR_IDENT, 1'b1), odd(15'h0005),
            16'h0000}, 16, rx);
        chk(rx[1], 16'h0001);
        chk(rx[2], odd(IDENT_VALUE));
        chk(rx[3], 16'h0002);
        chk(16'(rst_cnt), 16'h0000);
        i_host.frame('{aw(ADDR_IDENT, 1'b1), odd(RESET_CODE)}, 15, rx);
        chk(16'(rst_cnt), 16'h0000);
        i_host.frame('{aw(ADDR_IDENT, 1'b1), odd(RESET_CODE)}, 16, rx);
        chk(16'(rst_cnt), 16'h0001);
        chk(16'(o_ready), 16'h0000);
        wait_ready(n);
        i_host.frame('{aw(ADDR_STATUS, 1'b0), aw(ADDR_STATUS, 1'b0),
            16'h0000}, 16, rx);
        chk(rx[1], odd(15'h0010));
        i_host.pin(1'b0);
        i_host.tick(8);
        chk(16'(o_core_reset), 16'h0001);
        chk(16'(o_ready), 16'h0000);
        fork
            i_host.frame('{aw(ADDR_RATE, 1'b0), 16'h0000}, 16, rx);
            begin
                i_host.tick(12);
                chk(16'(spi_o.miso_oe), 16'h0001);
            end
        join
        chk(rx[1], 16'h0001);
        chk(16'(spi_o.miso_oe), 16'h0000);
        i_host.pin(1'b1);
        wait_ready(n);
        chk(16'(n >= SU), 16'h0001);
        // second reset in mid-run; pin level during it does not matter
        i_rst = 1'b1;
        i_host.pin(1'($urandom));
        i_host.tick(2);
        chk(16'(o_core_reset), 16'h0001);
        chk(16'(o_ready), 16'h0000);
        chk(16'(spi_o.miso_oe), 16'h0000);
        i_rst = 1'b0;
        i_host.pin(1'b1);
        wait_ready(n);
        chk(16'(n >= SU), 16'h0001);
        summarize();
    end
endmodule : gprs_core_tb_top
